/* File: src/aale_pkg.sv */
// Constants and types of the add and logic execute datapath
// Function
// - Add-immediate (11 111x k) puts acc + literal in acc; sets C, HC, Z.
// - AND-immediate (11 1001 k) puts acc & literal in acc; sets only Z.
// - Add-file (00 0111 d f) adds acc to the file register; sets C, HC, Z.
// - AND-file (00 0101 d f) ANDs acc with the file register; sets only Z.
// - In file forms d=0 writes the result to acc, d=1 to the file register.
// - A file operand at an I/O port is taken from the pins, not the latch.
// - A file result written to the timer count clears an assigned prescaler.
package aale_pkg;

  // Opcode fields
  localparam logic [1:0] LIT_HI       = 2'h3;
  localparam logic [1:0] FILE_HI      = 2'h0;
  localparam logic [2:0] ADD_IMM_NIB  = 3'h7;
  localparam logic [3:0] AND_IMM_NIB  = 4'h9;
  localparam logic [3:0] ADD_FILE_NIB = 4'h7;
  localparam logic [3:0] AND_FILE_NIB = 4'h5;
  localparam int         DIR_POS      = 7;
  localparam logic       DIR_TO_FILE  = 1'h1;

  // File addresses of the I/O ports and the timer count register
  localparam logic [6:0] PORT_A_ADDR  = 7'h10;
  localparam logic [6:0] PORT_B_ADDR  = 7'h11;
  localparam logic [6:0] TIMER_ADDR   = 7'h12;

  // APB byte offsets
  localparam logic [7:0] ACC_OFF      = 8'h00;
  localparam logic [7:0] FLAG_OFF     = 8'h04;
  localparam logic [7:0] CTRL_OFF     = 8'h08;
  localparam logic [7:0] COUNT_OFF    = 8'h0c;

  // Flag bit positions and reset values
  localparam int         C_POS        = 0;
  localparam int         HC_POS       = 1;
  localparam int         Z_POS        = 2;
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic       CTRL_EN_RST  = 1'h1;
  localparam logic [15:0] COUNT_RST   = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE, OP_ADD_IMM, OP_AND_IMM, OP_ADD_FILE, OP_AND_FILE
  } aale_op_t;

  typedef struct packed {
    logic z;
    logic half_carry_flag;
    logic carry;
  } aale_flags_t;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } aale_file_wr_t;

endpackage : aale_pkg

/* File: src/aale_exec.sv */
// Execute datapath for add and AND, immediate and file forms
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module aale_exec (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   instr_valid,
  input  wire logic [13:0]            instr,
  input  wire logic [7:0]             file_rd_data,
  input  wire logic [7:0]             pin_data,
  input  wire logic                   presc_on_timer,
  output logic [7:0]                  acc,
  output aale_pkg::aale_flags_t       flags,
  output aale_pkg::aale_file_wr_t     file_wr,
  output logic                        presc_clr,
  output logic                        exec_done
);

  logic [7:0]              acc_reg;
  logic [7:0]              acc_next;
  aale_pkg::aale_flags_t   flags_reg;
  aale_pkg::aale_flags_t   flags_next;
  aale_pkg::aale_file_wr_t file_wr_reg;
  aale_pkg::aale_file_wr_t file_wr_next;
  logic                    presc_clr_reg;
  logic                    done_reg;
  logic                    ctrl_en_reg;
  logic [15:0]             count_reg;
  logic [31:0]             prdata_reg;
  logic [31:0]             rd_mux;
  logic                    pready_reg;
  logic                    pslverr_reg;

  aale_pkg::aale_op_t      op;
  wire logic [1:0]         opc_hi;
  wire logic [3:0]         opc_nib;
  wire logic [6:0]         file_addr;
  wire logic               dir_bit;
  wire logic               go;
  wire logic               is_file;
  wire logic               is_add;
  wire logic               to_file;
  wire logic               addr_is_port;
  wire logic [7:0]         file_src;
  wire logic [7:0]         src;
  wire logic [8:0]         sum9;
  wire logic [4:0]         low5;
  wire logic [7:0]         result;
  wire logic               res_zero;
  wire logic               hit_timer;

  // Instruction field split and opcode decode
  assign opc_hi    = instr[13:12];
  assign opc_nib   = instr[11:8];
  assign file_addr = instr[6:0];
  assign dir_bit   = instr[aale_pkg::DIR_POS];
  assign op =
    (opc_hi == aale_pkg::LIT_HI && opc_nib[3:1] == aale_pkg::ADD_IMM_NIB)
      ? aale_pkg::OP_ADD_IMM :
    (opc_hi == aale_pkg::LIT_HI && opc_nib == aale_pkg::AND_IMM_NIB)
      ? aale_pkg::OP_AND_IMM :
    (opc_hi == aale_pkg::FILE_HI && opc_nib == aale_pkg::ADD_FILE_NIB)
      ? aale_pkg::OP_ADD_FILE :
    (opc_hi == aale_pkg::FILE_HI && opc_nib == aale_pkg::AND_FILE_NIB)
      ? aale_pkg::OP_AND_FILE : aale_pkg::OP_NONE;

  // Operation class and qualified execute strobe
  assign go      = instr_valid && ctrl_en_reg && (op != aale_pkg::OP_NONE);
  assign is_file = (op == aale_pkg::OP_ADD_FILE) ||
                   (op == aale_pkg::OP_AND_FILE);
  assign is_add  = (op == aale_pkg::OP_ADD_IMM) ||
                   (op == aale_pkg::OP_ADD_FILE);
  assign to_file = is_file && (dir_bit == aale_pkg::DIR_TO_FILE);

  // Operand select; ports are read from the pins, not the latch, so a
  // read-modify-write of a port sees what the outside world drives
  assign addr_is_port = (file_addr == aale_pkg::PORT_A_ADDR) ||
                        (file_addr == aale_pkg::PORT_B_ADDR);
  assign file_src = addr_is_port ? pin_data : file_rd_data;
  assign src      = is_file ? file_src : instr[7:0];

  // Adder with carry out of bit 7 and of bit 3
  assign sum9     = {1'b0, acc_reg} + {1'b0, src};
  assign low5     = {1'b0, acc_reg[3:0]} + {1'b0, src[3:0]};
  assign result   = is_add ? sum9[7:0] : (acc_reg & src);
  assign res_zero = (result == 8'h00);
  assign hit_timer = to_file && (file_addr == aale_pkg::TIMER_ADDR);

  // APB write strobes, taken at the completing edge only
  wire logic apb_wr;
  wire logic wr_acc;
  wire logic wr_flag;
  wire logic wr_ctrl;
  wire logic addr_ok;
  assign apb_wr  = psel && penable && pready_reg && pwrite;
  assign wr_acc  = apb_wr && (paddr == aale_pkg::ACC_OFF);
  assign wr_flag = apb_wr && (paddr == aale_pkg::FLAG_OFF);
  assign wr_ctrl = apb_wr && (paddr == aale_pkg::CTRL_OFF);
  assign addr_ok = (paddr == aale_pkg::ACC_OFF)  ||
                   (paddr == aale_pkg::FLAG_OFF) ||
                   (paddr == aale_pkg::CTRL_OFF) ||
                   (paddr == aale_pkg::COUNT_OFF);

  // Accumulator: an executing op that writes acc wins over a software write
  assign acc_next = (go && !to_file) ? result :
                    wr_acc ? pwdata[7:0] : acc_reg;

  // Flags: add ops set all three, AND ops only zero; an executing op
  // drops a software flag write of the same cycle as a whole
  wire logic flag_sw_wr;
  assign flag_sw_wr = wr_flag && !go;
  assign flags_next.z = go ? res_zero :
                        flag_sw_wr ? pwdata[aale_pkg::Z_POS] : flags_reg.z;
  assign flags_next.carry = (go && is_add) ? sum9[8] :
                            flag_sw_wr ? pwdata[aale_pkg::C_POS] :
                            flags_reg.carry;
  assign flags_next.half_carry_flag = (go && is_add) ? low5[4] :
                            flag_sw_wr ? pwdata[aale_pkg::HC_POS] :
                            flags_reg.half_carry_flag;

  // File write-back port
  assign file_wr_next.en   = go && to_file;
  assign file_wr_next.addr = file_addr;
  assign file_wr_next.data = result;

  // Read mux for the register file
  assign rd_mux =
    (paddr == aale_pkg::ACC_OFF)   ? {24'h000000, acc_reg} :
    (paddr == aale_pkg::FLAG_OFF)  ? {29'h00000000, flags_reg} :
    (paddr == aale_pkg::CTRL_OFF)  ? {31'h00000000, ctrl_en_reg} :
    (paddr == aale_pkg::COUNT_OFF) ? {16'h0000, count_reg} :
    32'h00000000;

  // Datapath state, one cycle per instruction
  // Write-back address and data pass every cycle; only en qualifies them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg       <= aale_pkg::ACC_RST;
      flags_reg     <= '0;
      file_wr_reg   <= '0;
      presc_clr_reg <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      acc_reg       <= acc_next;
      flags_reg     <= flags_next;
      file_wr_reg   <= file_wr_next;
      presc_clr_reg <= go && hit_timer && presc_on_timer;
      done_reg      <= go;
    end
  end

  // Control and executed-op counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_en_reg <= aale_pkg::CTRL_EN_RST;
      count_reg   <= aale_pkg::COUNT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_reg <= pwdata[0];
      end
      if (go) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // APB answer, one wait state: pready rises one cycle into the access
  // phase and falls right after the completing edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !addr_ok;
      prdata_reg  <= (psel && penable && !pready_reg) ? rd_mux
                                                      : 32'h00000000;
    end
  end

  // Outputs straight from the registers
  assign acc       = acc_reg;
  assign flags     = flags_reg;
  assign file_wr   = file_wr_reg;
  assign presc_clr = presc_clr_reg;
  assign exec_done = done_reg;
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;

  // Checks on the datapath
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Helper strobes that the checks share
  wire logic go_add_imm;
  wire logic go_and_f0;
  assign go_add_imm = go && (op == aale_pkg::OP_ADD_IMM);
  assign go_and_f0  = go && (op == aale_pkg::OP_AND_FILE) && !dir_bit;

  chk_add_imm_sum: assert property (
    go_add_imm |=> acc_reg == 8'($past(acc_reg) + $past(instr[7:0])))
    else $error("add immediate sum wrong");
  chk_and_imm_flags: assert property (
    go && op == aale_pkg::OP_AND_IMM |=> $stable(flags_reg.carry) &&
      $stable(flags_reg.half_carry_flag) && flags.z == (acc_reg == 8'h00))
    else $error("and immediate flags wrong");
  chk_add_file_carry: assert property (
    go && op == aale_pkg::OP_ADD_FILE |=> flags.carry ==
      (({1'b0, $past(acc_reg)} + {1'b0, $past(src)}) > 9'h0ff))
    else $error("add file carry wrong");
  chk_and_file_zero: assert property (
    go && op == aale_pkg::OP_AND_FILE && dir_bit |=>
      flags.z == (file_wr.data == 8'h00) && $stable(flags_reg.carry))
    else $error("and file zero wrong");
  chk_dir_dest: assert property (
    go && is_file |=> file_wr.en == $past(dir_bit) &&
      ($past(dir_bit) -> acc_reg == $past(acc_reg)))
    else $error("destination select wrong");
  chk_port_pins: assert property (
    go_and_f0 && addr_is_port |=>
      acc_reg == ($past(acc_reg) & $past(pin_data)))
    else $error("port operand not from pins");
  chk_timer_presc: assert property (
    go && to_file && file_addr == aale_pkg::TIMER_ADDR && presc_on_timer
      |=> presc_clr ##1 (!presc_clr || $past(go)))
    else $error("prescaler clear missing");
  chk_one_cycle: assert property (
    go |=> exec_done && count_reg == 16'($past(count_reg) + 16'h0001))
    else $error("op not done in one cycle");
  chk_half_carry: assert property (
    go_add_imm |=> flags.half_carry_flag ==
      (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(instr[3:0])}) > 5'h0f))
    else $error("half carry wrong");
  chk_apb_ready: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // Refused words leave the datapath alone
  chk_refused_quiet: assert property (
    instr_valid && !go && !wr_acc && !wr_flag |=>
      !exec_done && $stable(acc_reg) && $stable(flags_reg) &&
      !file_wr.en)
    else $error("refused op changed state");

  // Half carry of an add-file comes from the low nibbles
  chk_file_half: assert property (
    go && op == aale_pkg::OP_ADD_FILE |=> flags.half_carry_flag ==
      (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(src[3:0])}) > 5'h0f))
    else $error("add file half carry wrong");

  // Zero follows the 8-bit sum, whichever register takes it
  chk_add_zero: assert property (
    go && is_add |=>
      flags.z == (8'($past(acc_reg) + $past(src)) == 8'h00))
    else $error("add zero flag wrong");

  // An AND written back to a plain register uses its latch value
  chk_and_back_data: assert property (
    go && op == aale_pkg::OP_AND_FILE && to_file && !addr_is_port |=>
      file_wr.data == ($past(acc_reg) & $past(file_rd_data)))
    else $error("and file write-back data wrong");

  // An AND op leaves carry and half carry alone, software write or not
  chk_and_keeps_carry: assert property (
    go && !is_add |=> $stable(flags_reg.carry) &&
      $stable(flags_reg.half_carry_flag))
    else $error("and op touched carry");

  // An add from a port carries out of the pin level, not the latch
  chk_port_add: assert property (
    go && op == aale_pkg::OP_ADD_FILE && addr_is_port |=> flags.carry ==
      (({1'b0, $past(acc_reg)} + {1'b0, $past(pin_data)}) > 9'h0ff))
    else $error("port add carry wrong");

  // No prescaler clear unless a timer write-back asks for one
  chk_timer_quiet: assert property (
    !(go && hit_timer && presc_on_timer) |=> !presc_clr)
    else $error("spurious prescaler clear");

  // An unmapped address answers with an error and zero data
  chk_apb_unmapped: assert property (
    psel && penable && !pready && !addr_ok |=>
      pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access answered wrong");

  // Main scenarios the bench is meant to reach
  cov_add_carry: cover property (go_add_imm ##1 flags.carry);
  cov_file_back: cover property (go && to_file ##1 file_wr.en);
  cov_timer_clr: cover property (presc_clr);
  cov_apb_err:   cover property (pready && pslverr);
  cov_port_and:  cover property (go_and_f0 && addr_is_port);

endmodule : aale_exec

/* File: verif/aale_file_model.sv */
// File register space and port pins that face the execute datapath
`timescale 1ns/1ps
module aale_file_model (
  input  wire logic                    ref_clk,
  input  wire logic [6:0]              addr,
  input  wire aale_pkg::aale_file_wr_t file_wr,
  output logic [7:0]                   file_rd_data,
  output logic [7:0]                   pin_data
);
  logic [7:0] mem [128];

  // Known starting contents so the bench can predict every operand
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
  end

  // Write-back from the datapath lands at the clock edge
  always @(posedge ref_clk) begin
    if (file_wr.en === 1'h1) begin
      mem[file_wr.addr] <= file_wr.data;
    end
  end

  // Pins disagree with the latch, so a wrong source shows up
  assign file_rd_data = mem[addr];
  assign pin_data     = mem[addr] ^ 8'h5a;
endmodule : aale_file_model

/* File: verif/add_and_logic_execute_bench.sv */
// Self-checking bench for the add and logic execute datapath
`timescale 1ns/1ps
module add_and_logic_execute_bench;
  logic                    ref_clk, nrst, psel, penable, pwrite;
  logic                    pready, pslverr, err_seen, instr_valid;
  logic                    presc_on_timer, presc_clr, exec_done;
  logic                    done_seen, clr_seen;
  logic [7:0]              paddr, acc, file_rd_data, pin_data, v, res;
  logic [31:0]             pwdata, prdata, rd;
  logic [13:0]             instr;
  aale_pkg::aale_flags_t   flags;
  aale_pkg::aale_file_wr_t file_wr, wr_seen;
  int                      errors, n_checks;

  aale_exec i_aale_exec (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .file_rd_data(file_rd_data),
    .pin_data(pin_data), .presc_on_timer(presc_on_timer), .acc(acc),
    .flags(flags), .file_wr(file_wr), .presc_clr(presc_clr),
    .exec_done(exec_done));

  aale_file_model i_aale_file_model (.ref_clk(ref_clk), .addr(instr[6:0]),
    .file_wr(file_wr), .file_rd_data(file_rd_data), .pin_data(pin_data));

  // Clock at 100 ns period
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task close_out;
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd       = prdata;
    err_seen = pslverr;
    if (n >= 20) errors++;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // One instruction; pulses are captured in the cycle after it is taken
  task run_op(input logic [13:0] w);
    @(posedge ref_clk);
    instr_valid <= 1'h1;
    instr       <= w;
    @(posedge ref_clk);
    instr_valid <= 1'h0;
    #1;
    done_seen = exec_done;
    wr_seen   = file_wr;
    clr_seen  = presc_clr;
  endtask : run_op

  // Reference sum: {z, half carry, carry, result}
  function automatic logic [10:0] add_ref(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [8:0] s;
    logic       h;
    s = {1'h0, a} + {1'h0, b};
    h = ({1'h0, a[3:0]} + {1'h0, b[3:0]}) > 5'h0f;
    return {s[7:0] == 8'h00, h, s[8], s[7:0]};
  endfunction : add_ref

  task t_imm;
    logic [7:0]  ta [3];
    logic [7:0]  tk [3];
    logic [10:0] e;
    ta = '{8'h10, 8'h0f, 8'hff};
    tk = '{8'h15, 8'h01, 8'h01};
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, aale_pkg::ACC_OFF, 32'(ta[i]));
      e = add_ref(ta[i], tk[i]);
      run_op({2'h3, 3'h7, 1'(i), tk[i]});
      chk(32'(done_seen), 32'h1);
      chk(32'(acc), 32'(e[7:0]));
      chk(32'(flags), 32'(e[10:8]));
    end
    apb(1'h1, aale_pkg::ACC_OFF, 32'ha3);
    apb(1'h1, aale_pkg::FLAG_OFF, 32'h3);
    run_op({2'h3, 4'h9, 8'h5f});
    chk(32'(acc), 32'h03);
    chk(32'(flags), 32'h3);
    run_op({2'h3, 4'h9, 8'h00});
    chk(32'({acc, 5'h0, flags}), 32'h0007);
  endtask : t_imm

  // Both file forms with both destinations
  task t_file;
    logic [10:0] e;
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, aale_pkg::ACC_OFF, 32'h17);
      apb(1'h1, aale_pkg::FLAG_OFF, 32'h3);
      v   = i_aale_file_model.mem[7'h25];
      e   = add_ref(8'h17, v);
      res = i[1] ? (8'h17 & v) : e[7:0];
      run_op({2'h0, i[1] ? 4'h5 : 4'h7, 1'(i), 7'h25});
      if (i[1]) chk(32'(flags), {29'h0, res == 8'h00, 2'h3});
      else chk(32'(flags), 32'(e[10:8]));
      chk(32'(acc), i[0] ? 32'h17 : 32'(res));
      chk(32'(wr_seen), {16'h0, 1'(i), 7'h25, res});
    end
  endtask : t_file

  task t_port_timer;
    apb(1'h1, aale_pkg::ACC_OFF, 32'h01);
    v = i_aale_file_model.mem[7'h10] ^ 8'h5a;
    run_op({2'h0, 4'h7, 1'h0, 7'h10});
    chk(32'(acc), 32'(8'(v + 8'h01)));
    run_op({2'h0, 4'h5, 1'h0, 7'h10});
    chk(32'(acc), 32'(8'(v + 8'h01) & v));
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      presc_on_timer <= i[1];
      run_op({2'h0, 4'h5, 1'(i), 7'h12});
      chk(32'(clr_seen), 32'(i[1] & i[0]));
    end
  endtask : t_port_timer

  task t_refuse_order;
    logic [31:0] cnt;
    apb(1'h1, aale_pkg::ACC_OFF, 32'h01);
    run_op(14'h3800);
    chk(32'({done_seen, acc}), 32'h001);
    apb(1'h1, aale_pkg::CTRL_OFF, 32'h0);
    run_op({2'h3, 4'hf, 8'h05});
    chk(32'({done_seen, acc}), 32'h001);
    apb(1'h1, aale_pkg::CTRL_OFF, 32'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk({rd[30:0], err_seen}, 32'h1);
    apb(1'h0, aale_pkg::COUNT_OFF, 32'h0);
    cnt = rd;
    @(posedge ref_clk);
    instr_valid <= 1'h1;
    instr       <= {2'h3, 4'he, 8'h01};
    @(posedge ref_clk);
    instr       <= {2'h3, 4'he, 8'h02};
    @(posedge ref_clk);
    instr_valid <= 1'h0;
    #1;
    chk(32'(acc), 32'h04);
    apb(1'h0, aale_pkg::COUNT_OFF, 32'h0);
    chk(rd, cnt + 32'h2);
  endtask : t_refuse_order

  // Watchdog well beyond the roughly 140 cycles the tests need
  initial begin
    #2000000;
    errors++;
    close_out();
  end

  initial begin
    {nrst, psel, penable, pwrite, instr_valid, presc_on_timer} = 6'h0;
    {paddr, pwdata, instr} = '0;
    errors   = 0;
    n_checks = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'h1;
    #1;
    chk(32'({acc, 5'h0, flags, file_wr}), 32'h0);
    apb(1'h0, aale_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h1);
    t_imm();
    t_file();
    t_port_timer();
    t_refuse_order();
    close_out();
  end
endmodule : add_and_logic_execute_bench
